//--- adcpp_pkg.sv
// shared constants and types for the primary channel post-processing block
package adcpp_pkg;

  // data path widths
  localparam int RES_W = 24;           // conversion result width
  localparam int CNT_W = 8;            // threshold and result counter width

  // register byte addresses on the AXI4-Lite bus
  localparam logic [31:0] CFG_ADDR      = 32'hFFFF0518;
  localparam logic [31:0] RESULT_ADDR   = 32'hFFFF051C;
  localparam logic [31:0] THRESH_ADDR   = 32'hFFFF0600;
  localparam logic [31:0] TH_LIMIT_ADDR = 32'hFFFF0604;
  localparam logic [31:0] TH_VALUE_ADDR = 32'hFFFF0608;
  localparam logic [31:0] RC_LIMIT_ADDR = 32'hFFFF060C;
  localparam logic [31:0] RC_VALUE_ADDR = 32'hFFFF0610;
  localparam logic [31:0] STATUS_ADDR   = 32'hFFFF0614;
  localparam logic [31:0] INT_EN_ADDR   = 32'hFFFF0618;
  localparam logic [31:0] INT_CLR_ADDR  = 32'hFFFF061C;
  localparam logic [31:0] ACCUM_ADDR    = 32'hFFFF0620;

  // configuration register field positions
  localparam int CFG_GSW_BIT = 7;      // ground switch enable
  localparam int CFG_ACC_LO  = 5;      // accumulator mode, two bits
  localparam int CFG_CMP_LO  = 3;      // comparator mode, two bits
  localparam int CFG_OVR_BIT = 2;      // coarse overrange enable
  localparam int CFG_RES_BIT = 1;      // series resistor enable
  localparam int CFG_RC_BIT  = 0;      // result counter enable

  // status, enable and clear register bit positions
  localparam int ST_W     = 8;         // status width
  localparam int ST_CONV  = 0;         // conversion interrupt event
  localparam int ST_READY = 1;         // primary ready level
  localparam int ST_CMP   = 2;         // threshold comparator event
  localparam int ST_OVR   = 3;         // coarse overrange event
  localparam int ST_ACC   = 6;         // accumulator comparator event

  // values after reset
  localparam logic [7:0]       CFG_RESET    = 8'h00;
  localparam logic [ST_W-1:0]  INT_EN_RESET = 8'h00;
  localparam logic [RES_W-1:0] THRESH_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] LIMIT_RESET  = 8'h00;

  // overrange qualifying time and its cycle count at the bus clock
  localparam int CLK_PERIOD_NS   = 10;
  localparam int OVR_QUAL_NS     = 125000;
  localparam int OVR_QUAL_CYCLES = (OVR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // accumulator modes
  typedef enum logic [1:0] {
    ACC_OFF     = 2'h0,
    ACC_CLAMP   = 2'h1,
    ACC_SIGNED  = 2'h2,
    ACC_COMPARE = 2'h3
  } adcpp_acc_mode_t;

  // threshold comparator modes
  typedef enum logic [1:0] {
    CMP_OFF       = 2'h0,
    CMP_LEVEL     = 2'h1,
    CMP_COUNT_RST = 2'h2,
    CMP_COUNT_DEC = 2'h3
  } adcpp_cmp_mode_t;

endpackage

//--- adcpp_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the register block and the threshold comparator
interface adcpp_cmp_if #(
  parameter int RES_W = 24,
  parameter int CNT_W = 8
);
  logic                 valid;     // one-cycle pulse per conversion
  logic [RES_W-1:0]     magnitude; // absolute value of the result
  logic [RES_W-1:0]     threshold; // programmed threshold
  logic [CNT_W-1:0]     limit;     // programmed count limit
  logic [1:0]           mode;      // comparator mode field
  logic [CNT_W-1:0]     count;     // current threshold count
  logic                 hit;       // one-cycle comparator event

  modport ctrl (output valid, magnitude, threshold, limit, mode, input count, hit);
  modport cmp  (input valid, magnitude, threshold, limit, mode, output count, hit);
endinterface
`default_nettype wire

//--- adcpp_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// threshold comparator with plain, count-reset and count-decrement modes
module adcpp_cmp
  import adcpp_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  adcpp_cmp_if.cmp  cif
);

  logic [CW-1:0] count_r;   // threshold count
  logic [CW-1:0] count_nxt; // its next value
  logic          above;     // result meets threshold
  logic [CW-1:0] count_inc; // count plus one
  logic          reached;   // incremented count hits the limit
  logic          counting;  // one of the count modes

  assign above     = cif.magnitude >= cif.threshold;
  assign count_inc = count_r + CW'(1);
  assign reached   = count_inc == cif.limit;
  assign counting  = cif.mode[1];

  // event: level mode on every qualifying result, count modes at the limit
  assign cif.hit = cif.valid & above & ((cif.mode == CMP_LEVEL) | (counting & reached));

  // count update per conversion
  always_comb begin
    count_nxt = count_r;
    if (!counting) begin
      count_nxt = '0;
    end else if (cif.valid & above) begin
      count_nxt = reached ? '0 : count_inc;
    end else if (cif.valid & (cif.mode == CMP_COUNT_RST)) begin
      count_nxt = '0;
    end else if (cif.valid & (count_r != '0)) begin
      count_nxt = count_r - CW'(1);
    end
  end

  // count register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign cif.count = count_r;

endmodule
`default_nettype wire

//--- adcpp_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcpp_top
  import adcpp_pkg::*;
#(
  parameter int OVR_QUAL = OVR_QUAL_CYCLES
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             conv_valid,
  input  wire logic [RES_W-1:0] conv_data,
  input  wire logic             coarse_out_of_range,
  output logic                  ground_switch_pin_on,
  output logic                  ground_series_resistor_on,
  output logic                  primary_overrange_enable,
  output logic                  irq
);

  // merge byte lanes of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // write channel holding registers
  logic              aw_full_r;  // write address captured
  logic [31:0]       aw_addr_r;  // captured write address
  logic              w_full_r;   // write data captured
  logic [31:0]       w_data_r;   // captured write data
  logic [3:0]        w_strb_r;   // captured byte strobes
  logic              bvalid_r;   // write response pending
  logic [1:0]        bresp_r;    // write response code
  // read channel registers
  logic              rvalid_r;   // read data pending
  logic [31:0]       rdata_r;    // read data
  logic [1:0]        rresp_r;    // read response code

  // software-visible registers and internal state
  logic [7:0]        cfg_r;      // extended configuration
  logic [RES_W-1:0]  thresh_r;   // primary threshold
  logic [CNT_W-1:0]  th_limit_r; // threshold count limit
  logic [CNT_W-1:0]  rc_limit_r; // result count limit
  logic [CNT_W-1:0]  rc_value_r; // result count value
  logic [ST_W-1:0]   status_r;   // sticky events
  logic [ST_W-1:0]   int_en_r;   // interrupt enables
  logic              ready_r;    // primary result ready
  logic [RES_W-1:0]  result_r;   // primary result
  logic [31:0]       accum_r;    // accumulator total
  logic [31:0]       ovr_cnt_r;  // out-of-range hold counter
  logic              irq_r;      // interrupt output register

  // next values
  logic [7:0]        cfg_nxt;
  logic [RES_W-1:0]  thresh_nxt;
  logic [CNT_W-1:0]  th_limit_nxt;
  logic [CNT_W-1:0]  rc_limit_nxt;
  logic [CNT_W-1:0]  rc_value_nxt;
  logic [ST_W-1:0]   status_nxt;
  logic [ST_W-1:0]   int_en_nxt;
  logic              ready_nxt;
  logic [31:0]       accum_nxt;
  logic [31:0]       ovr_cnt_nxt;

  // bus handshake terms
  logic              aw_take;    // write address accepted
  logic              w_take;     // write data accepted
  logic              wr_fire;    // register write executes
  logic              ar_take;    // read address accepted
  logic              wr_hit;     // write address mapped
  logic              rd_hit;     // read address mapped
  logic [31:0]       rd_word;    // read mux output

  // write decodes
  logic              wr_cfg;
  logic              wr_thresh;
  logic              wr_th_limit;
  logic              wr_rc_limit;
  logic              wr_int_en;
  logic              wr_int_clr;
  logic              rd_result;  // result register read accepted

  // conversion path terms
  adcpp_acc_mode_t   acc_mode;   // accumulator mode field
  logic              neg;        // result is negative
  logic [RES_W-1:0]  mag;        // result magnitude
  logic [31:0]       ext;        // result sign-extended
  logic [31:0]       mag32;      // magnitude zero-extended
  logic [31:0]       acc_add;    // wrapping signed sum
  logic [31:0]       acc_clamp;  // sum clamped at zero
  logic              acc_hit;    // accumulator comparator event
  logic [CNT_W-1:0]  rc_inc;     // result count plus one
  logic              rc_match;   // result count reached limit
  logic              conv_evt;   // conversion interrupt event
  logic              ovr_active; // enabled and out of range
  logic              ovr_set;    // qualified overrange event
  logic [ST_W-1:0]   st_set;     // events this cycle
  logic [ST_W-1:0]   st_clr;     // software clears this cycle
  logic [ST_W-1:0]   st_view;    // status as read

  adcpp_cmp_if #(.RES_W(RES_W), .CNT_W(CNT_W)) cif ();

  // threshold comparator
  adcpp_cmp #(
    .CW(CNT_W)
  ) u_cmp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif.cmp)
  );

  // bus handshakes: one write and one read in flight
  assign aw_take = s_axi_awvalid & ~aw_full_r;
  assign w_take  = s_axi_wvalid & ~w_full_r;
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign ar_take = s_axi_arvalid & ~rvalid_r;

  // write decode
  assign wr_cfg      = wr_fire & (aw_addr_r == CFG_ADDR);
  assign wr_thresh   = wr_fire & (aw_addr_r == THRESH_ADDR);
  assign wr_th_limit = wr_fire & (aw_addr_r == TH_LIMIT_ADDR);
  assign wr_rc_limit = wr_fire & (aw_addr_r == RC_LIMIT_ADDR);
  assign wr_int_en   = wr_fire & (aw_addr_r == INT_EN_ADDR);
  assign wr_int_clr  = wr_fire & (aw_addr_r == INT_CLR_ADDR);
  assign wr_hit      = (aw_addr_r == CFG_ADDR) | (aw_addr_r == THRESH_ADDR) | (aw_addr_r == TH_LIMIT_ADDR)
                     | (aw_addr_r == RC_LIMIT_ADDR) | (aw_addr_r == INT_EN_ADDR) | (aw_addr_r == INT_CLR_ADDR);
  assign rd_result   = ar_take & (s_axi_araddr == RESULT_ADDR);

  // bus outputs
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      CFG_ADDR:      rd_word = {24'h000000, cfg_r};
      RESULT_ADDR:   rd_word = {8'h00, result_r};
      THRESH_ADDR:   rd_word = {8'h00, thresh_r};
      TH_LIMIT_ADDR: rd_word = {24'h000000, th_limit_r};
      TH_VALUE_ADDR: rd_word = {24'h000000, cif.count};
      RC_LIMIT_ADDR: rd_word = {24'h000000, rc_limit_r};
      RC_VALUE_ADDR: rd_word = {24'h000000, rc_value_r};
      STATUS_ADDR:   rd_word = {24'h000000, st_view};
      INT_EN_ADDR:   rd_word = {24'h000000, int_en_r};
      INT_CLR_ADDR:  rd_word = '0;
      ACCUM_ADDR:    rd_word = accum_r;
      default:       rd_hit  = 1'b0;
    endcase
  end

  // register writes with byte strobes
  assign cfg_nxt      = wr_cfg ? 8'(merge({24'h000000, cfg_r}, w_data_r, w_strb_r)) : cfg_r;
  assign thresh_nxt   = wr_thresh ? RES_W'(merge({8'h00, thresh_r}, w_data_r, w_strb_r)) : thresh_r;
  assign th_limit_nxt = wr_th_limit ? CNT_W'(merge({24'h000000, th_limit_r}, w_data_r, w_strb_r)) : th_limit_r;
  assign rc_limit_nxt = wr_rc_limit ? CNT_W'(merge({24'h000000, rc_limit_r}, w_data_r, w_strb_r)) : rc_limit_r;
  assign int_en_nxt   = wr_int_en ? ST_W'(merge({24'h000000, int_en_r}, w_data_r, w_strb_r)) : int_en_r;
  assign st_clr       = wr_int_clr ? ST_W'(merge(32'h00000000, w_data_r, w_strb_r)) : '0;

  // analog control outputs
  assign ground_switch_pin_on      = cfg_r[CFG_GSW_BIT];
  assign ground_series_resistor_on = cfg_r[CFG_RES_BIT];
  assign primary_overrange_enable  = cfg_r[CFG_OVR_BIT];

  // conversion magnitude and extensions
  assign acc_mode = adcpp_acc_mode_t'(cfg_r[CFG_ACC_LO +: 2]);
  assign neg      = conv_data[RES_W-1];
  assign mag      = neg ? (~conv_data + RES_W'(1)) : conv_data;
  assign ext      = {{(32-RES_W){neg}}, conv_data};
  assign mag32    = {{(32-RES_W){1'b0}}, mag};

  // accumulator arithmetic, sums wrap at 32 bits
  assign acc_add   = accum_r + ext;
  assign acc_clamp = ~neg ? acc_add : ((accum_r < mag32) ? 32'h00000000 : (accum_r - mag32));

  // accumulator next value per mode
  always_comb begin
    accum_nxt = accum_r;
    case (acc_mode)
      ACC_OFF:     accum_nxt = '0;
      ACC_CLAMP:   accum_nxt = conv_valid ? acc_clamp : accum_r;
      ACC_SIGNED:  accum_nxt = conv_valid ? acc_add : accum_r;
      ACC_COMPARE: accum_nxt = conv_valid ? acc_clamp : accum_r;
      default:     accum_nxt = accum_r;
    endcase
  end

  // accumulator comparator against the threshold
  assign acc_hit = conv_valid & (acc_mode == ACC_COMPARE) & ($signed(accum_nxt) >= $signed({8'h00, thresh_r}));

  // comparator link
  assign cif.valid     = conv_valid;
  assign cif.magnitude = mag;
  assign cif.threshold = thresh_r;
  assign cif.limit     = th_limit_r;
  assign cif.mode      = cfg_r[CFG_CMP_LO +: 2];

  // result count mode
  assign rc_inc       = rc_value_r + CNT_W'(1);
  assign rc_match     = rc_inc == rc_limit_r;
  assign rc_value_nxt = ~cfg_r[CFG_RC_BIT] ? '0 : (conv_valid ? (rc_match ? '0 : rc_inc) : rc_value_r);
  assign conv_evt     = conv_valid & (~cfg_r[CFG_RC_BIT] | rc_match);

  // coarse overrange qualification
  assign ovr_active  = cfg_r[CFG_OVR_BIT] & coarse_out_of_range;
  assign ovr_set     = ovr_active & (ovr_cnt_r == 32'(OVR_QUAL));
  assign ovr_cnt_nxt = ~ovr_active ? '0 : ((ovr_cnt_r > 32'(OVR_QUAL)) ? ovr_cnt_r : ovr_cnt_r + 32'h00000001);

  // sticky status, set wins over clear
  always_comb begin
    st_set           = '0;
    st_set[ST_CONV]  = conv_evt;
    st_set[ST_CMP]   = cif.hit;
    st_set[ST_OVR]   = ovr_set;
    st_set[ST_ACC]   = acc_hit;
    st_view          = status_r;
    st_view[ST_READY] = ready_r;
  end
  assign status_nxt = (status_r & ~st_clr & ~(rd_result ? ST_W'(1) : ST_W'(0))) | st_set;

  // ready flag: new conversion wins over a result read
  assign ready_nxt = conv_valid | (ready_r & ~rd_result);

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_r <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // configuration and limit registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r      <= CFG_RESET;
      thresh_r   <= THRESH_RESET;
      th_limit_r <= LIMIT_RESET;
      rc_limit_r <= LIMIT_RESET;
      int_en_r   <= INT_EN_RESET;
    end else begin
      cfg_r      <= cfg_nxt;
      thresh_r   <= thresh_nxt;
      th_limit_r <= th_limit_nxt;
      rc_limit_r <= rc_limit_nxt;
      int_en_r   <= int_en_nxt;
    end
  end

  // conversion state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accum_r    <= '0;
      rc_value_r <= '0;
      ovr_cnt_r  <= '0;
      ready_r    <= 1'b0;
      status_r   <= '0;
    end else begin
      accum_r    <= accum_nxt;
      rc_value_r <= rc_value_nxt;
      ovr_cnt_r  <= ovr_cnt_nxt;
      ready_r    <= ready_nxt;
      status_r   <= status_nxt;
    end
  end

  // result register holds while ready is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= '0;
    end else if (conv_valid & ~ready_r) begin
      result_r <= conv_data;
    end
  end

  // level interrupt from enabled sticky bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & int_en_r);
    end
  end

  assign irq = irq_r;

endmodule
`default_nettype wire

//--- adcpp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// protocol and output checks seen at the top ports
module adcpp_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        conv_valid,
  input wire logic        coarse_out_of_range,
  input wire logic        ground_switch_pin_on,
  input wire logic        ground_series_resistor_on,
  input wire logic        primary_overrange_enable,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // config pins move only on the edge where a write retires
  chk_gsw_on_write: assert property ($changed(ground_switch_pin_on) |-> $rose(s_axi_bvalid))
    else $error("ground switch moved without a write");
  chk_res_on_write: assert property ($changed(ground_series_resistor_on) |-> $rose(s_axi_bvalid))
    else $error("series resistor moved without a write");
  chk_ovr_on_write: assert property ($changed(primary_overrange_enable) |-> $rose(s_axi_bvalid))
    else $error("overrange enable moved without a write");
  // responses stand until taken
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answering");
  // answer latencies of the register bus
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  // an interrupt rises only after a conversion, a register write or an overrange
  chk_irq_cause: assert property ($rose(irq) |-> $past(conv_valid, 2) || $past(s_axi_bvalid)
    || $past(coarse_out_of_range, 2))
    else $error("interrupt rose without a cause");
endmodule
bind adcpp_top adcpp_asserts u_adcpp_asserts (.*);
`default_nettype wire

//--- adcpp_src.sv
`timescale 1ns/1ps
`default_nettype none
// filter result path: one-cycle result pulses and the coarse comparator level
module adcpp_src
  import adcpp_pkg::*;
(
  input  wire logic            aclk,
  output var logic             conv_valid,
  output var logic [RES_W-1:0] conv_data,
  output var logic             coarse_out_of_range
);
  // quiet lines at time zero
  initial begin
    conv_valid = 1'b0;
    conv_data = '0;
    coarse_out_of_range = 1'b0;
  end
  // one result for one cycle; idle data shows the inverse of the last value
  task send(input logic [RES_W-1:0] d);
    conv_valid <= 1'b1;
    conv_data <= d;
    @(posedge aclk);
    conv_valid <= 1'b0;
    conv_data <= ~d;
    @(posedge aclk);
  endtask
  // hold the coarse comparator out of range for n cycles
  task out_of_range(input int n);
    coarse_out_of_range <= 1'b1;
    repeat (n) @(posedge aclk);
    coarse_out_of_range <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the post-processing block
module tb_top
  import adcpp_pkg::*;
;
  logic             aclk, aresetn;
  logic [31:0]      s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, coarse_out_of_range;
  logic             conv_valid, ground_switch_pin_on, ground_series_resistor_on, primary_overrange_enable;
  logic [RES_W-1:0] conv_data;
  int               n_fail, check_count;
  adcpp_top #(.OVR_QUAL(8)) u_adcpp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv_valid, .conv_data, .coarse_out_of_range, .ground_switch_pin_on, .ground_series_resistor_on,
    .primary_overrange_enable, .irq);
  adcpp_src u_adcpp_src (.aclk, .conv_valid, .conv_data, .coarse_out_of_range);
  always #5 aclk = ~aclk;
  task print_verdict;
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // value compare and response compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chkr(input logic [1:0] exp);
    chk({30'h0, resp}, {30'h0, exp});
  endtask
  // write: address and data together, each released when taken
  task wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
    @(posedge aclk);
  endtask
  // read: address held until taken, data taken at the rvalid edge
  task rd(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
    @(posedge aclk);
  endtask
  task st(input logic [31:0] exp, input logic [31:0] m);
    rd(STATUS_ADDR);
    chk(rdat & m, exp);
  endtask
  task s_regs;
    rd(CFG_ADDR);
    chk(rdat, 32'h00);
    rd(32'hFFFF0700);
    chkr(RESP_SLVERR);
    wr(ACCUM_ADDR, 32'h5);
    chkr(RESP_SLVERR);
    wr(CFG_ADDR, 32'h82);
    chk({30'h0, ground_switch_pin_on, ground_series_resistor_on}, 32'h3);
    wr(CFG_ADDR, 32'h04);
    s_axi_wstrb <= 4'hE;
    wr(CFG_ADDR, 32'hFF);
    s_axi_wstrb <= 4'hF;
    rd(CFG_ADDR);
    chk({21'h0, rdat[7:0], ground_switch_pin_on, ground_series_resistor_on, primary_overrange_enable}, 32'h21);
  endtask
  task s_rc;
    wr(RC_LIMIT_ADDR, 32'h3);
    wr(CFG_ADDR, 32'h01);
    repeat (2) u_adcpp_src.send(24'h11);
    st(32'h0, 32'h1);
    u_adcpp_src.send(24'h11);
    st(32'h1, 32'h1);
    rd(RESULT_ADDR);
    st(32'h0, 32'h3);
    wr(INT_EN_ADDR, 32'h1);
    wr(CFG_ADDR, 32'h00);
    u_adcpp_src.send(24'h7);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    u_adcpp_src.send(24'h9);
    rd(RESULT_ADDR);
    chk(rdat, 32'h7);
    wr(INT_EN_ADDR, 32'h0);
  endtask
  // the converter never runs in low power here, so overrange may be enabled
  task s_ovr;
    wr(CFG_ADDR, 32'h04);
    wr(INT_CLR_ADDR, 32'hFF);
    u_adcpp_src.out_of_range(8);
    st(32'h0, 32'h8);
    u_adcpp_src.out_of_range(10);
    st(32'h8, 32'h8);
    wr(INT_EN_ADDR, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(INT_EN_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(INT_EN_ADDR, 32'h8);
    wr(INT_CLR_ADDR, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(CFG_ADDR, 32'h00);
    u_adcpp_src.out_of_range(12);
    st(32'h0, 32'h8);
  endtask
  task s_cmp;
    wr(THRESH_ADDR, 32'h64);
    wr(TH_LIMIT_ADDR, 32'h3);
    wr(CFG_ADDR, 32'h08);
    u_adcpp_src.send(24'hFFFF9C);
    st(32'h4, 32'h4);
    wr(INT_CLR_ADDR, 32'hFF);
    u_adcpp_src.send(24'h63);
    st(32'h0, 32'h4);
    wr(CFG_ADDR, 32'h10);
    repeat (2) u_adcpp_src.send(24'h64);
    u_adcpp_src.send(24'h32);
    rd(TH_VALUE_ADDR);
    chk(rdat, 32'h0);
    repeat (2) u_adcpp_src.send(24'h64);
    st(32'h0, 32'h4);
    u_adcpp_src.send(24'h64);
    st(32'h4, 32'h4);
    wr(CFG_ADDR, 32'h18);
    wr(INT_CLR_ADDR, 32'hFF);
    repeat (2) u_adcpp_src.send(24'h64);
    u_adcpp_src.send(24'h32);
    rd(TH_VALUE_ADDR);
    chk(rdat, 32'h1);
    repeat (2) u_adcpp_src.send(24'h64);
    st(32'h4, 32'h4);
    wr(CFG_ADDR, 32'h00);
    wr(INT_CLR_ADDR, 32'hFF);
    u_adcpp_src.send(24'hC8);
    st(32'h0, 32'h4);
  endtask
  // accumulator modes; two conversions in mode 00 between modes
  task acc_off;
    wr(CFG_ADDR, 32'h00);
    repeat (2) u_adcpp_src.send(24'h1);
    rd(ACCUM_ADDR);
    chk(rdat, 32'h0);
  endtask
  task s_acc;
    wr(CFG_ADDR, 32'h20);
    u_adcpp_src.send(24'h5);
    u_adcpp_src.send(24'hFFFFF8);
    rd(ACCUM_ADDR);
    chk(rdat, 32'h0);
    u_adcpp_src.send(24'h3);
    rd(ACCUM_ADDR);
    chk(rdat, 32'h3);
    acc_off();
    wr(CFG_ADDR, 32'h40);
    u_adcpp_src.send(24'hFFFFFC);
    rd(ACCUM_ADDR);
    chk(rdat, 32'hFFFFFFFC);
    acc_off();
    wr(THRESH_ADDR, 32'hA);
    wr(CFG_ADDR, 32'h60);
    wr(INT_CLR_ADDR, 32'hFF);
    wr(INT_EN_ADDR, 32'h40);
    u_adcpp_src.send(24'h4);
    st(32'h0, 32'h40);
    u_adcpp_src.send(24'h8);
    st(32'h40, 32'h40);
    chk({31'h0, irq}, 32'h1);
    acc_off();
    wr(CFG_ADDR, 32'h20);
    repeat (513) u_adcpp_src.send(24'h7FFFFF);
    rd(ACCUM_ADDR);
    chk(rdat, 32'h007FFDFF);
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs();
    s_rc();
    s_ovr();
    s_cmp();
    s_acc();
    print_verdict();
  end
endmodule
`default_nettype wire
